// >>> hw/acs_regs.vh
// register offsets, field positions, reset values and timing for acs
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
`define ACS_OFS_CTL_A        8'h00
`define ACS_OFS_CTL_B        8'h04
`define ACS_OFS_CONFIG_ONE_REG         8'h08
`define ACS_OFS_CONFIG_TWO_REG         8'h0C
`define ACS_OFS_SC2          8'h10
`define ACS_OFS_SC3          8'h14
`define ACS_OFS_RES_A        8'h18
`define ACS_OFS_RES_B        8'h1C
`define ACS_OFS_CV1          8'h20
`define ACS_OFS_CV2          8'h24
`define ACS_CTL_FLAG_BIT     7
`define ACS_CTL_IEN_BIT      6
`define ACS_CH_OFF           5'h1F
`define ACS_CONFIG_ONE_REG_LPC_BIT     7
`define ACS_CONFIG_ONE_REG_DIV_LSB     5
`define ACS_CONFIG_ONE_REG_LSMP_BIT    4
`define ACS_CONFIG_ONE_REG_MODE_LSB    2
`define ACS_CONFIG_ONE_REG_ICLK_LSB    0
`define ACS_CONFIG_TWO_REG_ACKEN_BIT   3
`define ACS_CONFIG_TWO_REG_HSC_BIT     2
`define ACS_CONFIG_TWO_REG_LSTS_LSB    0
`define ACS_SC2_ACT_BIT      7
`define ACS_SC2_TRG_BIT      6
`define ACS_SC2_ACFE_BIT     5
`define ACS_SC2_ACFGT_BIT    4
`define ACS_SC2_ACREN_BIT    3
`define ACS_SC3_CONT_BIT     3
`define ACS_SC3_AVERAGING_ENABLE_BIT     2
`define ACS_SC3_AVERAGING_COUNT_SELECT_LSB     0
`define ACS_MODE_8B          2'h0
`define ACS_ICLK_BUS2        2'h1
`define ACS_ICLK_ALT         2'h2
`define ACS_ICLK_ASYNC       2'h3
`define ACS_SAMPLE_BASE      8'h04
`define ACS_HSC_ADDER        8'h02
`define ACS_BCT_8B           8'h11
`define ACS_BCT_HI           8'h14
`define ACS_LST_00           8'h14
`define ACS_LST_01           8'h0C
`define ACS_LST_10           8'h06
`define ACS_LST_11           8'h02
`define ACS_SFC_BUS          8'h05
`define ACS_SFC_LONG         8'h03
`define ACS_SFC_SHORT        8'h05
`define ACS_CLK_PERIOD_NS    50
`define ACS_STARTUP_NS       5000
`define ACS_STARTUP_CYC      ((`ACS_STARTUP_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`endif

// >>> hw/acs_sequencer.v
// conversion sequencer of a successive-approximation converter
`default_nettype none
`include "acs_regs.vh"

module acs_sequencer #(
   parameter ASYNC_DIV = 4,
   parameter RES_W     = 12
) (
   input  wire        i_core_clk,     // core clock, 20 MHz
   input  wire        i_resetn,       // async reset, active low
   input  wire [7:0]  i_addr,         // register byte address
   input  wire [31:0] i_wr_data,      // write data
   input  wire        i_wr_en,        // write strobe
   input  wire        i_rd_en,        // read strobe
   input  wire [11:0] i_analog_in,    // digitised input level
   input  wire        i_alt_clk_tick, // alternate clock source pulse
   input  wire        i_hw_trigger,   // hardware trigger level
   input  wire        i_trig_sel_a,   // trigger select, primary
   input  wire        i_trig_sel_b,   // trigger select, secondary
   input  wire        i_normal_stop,  // normal stop mode level
   input  wire        i_lp_stop,      // low-power stop mode level
   output wire [31:0] o_rd_data,      // read data, cycle after strobe
   output wire        o_irq,          // conversion complete interrupt
   output wire        o_busy,         // conversion sequence active
   output wire        o_sampling,     // input connected to sampler
   output wire        o_async_clk_on  // async generator running
);
   localparam ST_IDLE   = 3'h0;
   localparam ST_WARM   = 3'h1;
   localparam ST_FIRST  = 3'h2;
   localparam ST_SFC    = 3'h3;
   localparam ST_SAMPLE = 3'h4;
   localparam ST_CONV   = 3'h5;
   localparam integer STARTUP_CYC = `ACS_STARTUP_CYC;
   localparam [7:0]   STARTUP     = STARTUP_CYC[7:0];

   reg  [2:0]       st_reg;
   reg  [2:0]       st_next;
   reg  [7:0]       cnt_reg;
   reg  [7:0]       cnt_next;
   reg              done_step;
   reg  [1:0]       ien_reg;
   reg  [4:0]       ch_a_reg;
   reg  [4:0]       ch_b_reg;
   reg  [7:0]       config_one_reg_reg;
   reg  [3:0]       config_two_reg_reg;
   reg  [5:3]       sc2_reg;
   reg              trg_reg;
   reg  [3:0]       sc3_reg;
   reg  [RES_W-1:0] cv1_reg;
   reg  [RES_W-1:0] cv2_reg;
   reg  [RES_W-1:0] res_reg [0:1];
   reg  [1:0]       flag_reg;
   reg  [1:0]       irq_pend_reg;
   reg              act_ch_reg;
   reg  [4:0]       avg_cnt_reg;
   reg  [16:0]      acc_reg;
   reg  [11:0]      samp_reg;
   reg  [2:0]       div_reg;
   reg              half_reg;
   reg  [7:0]       async_cnt_reg;
   reg              async_on_reg;
   reg              trig_q_reg;
   reg              nstop_q_reg;
   reg              lpstop_q_reg;
   reg  [31:0]      rd_data_reg;
   reg              irq_reg;
   reg              busy_reg;
   reg              sampling_reg;
   reg  [31:0]      rd_mux;
   reg  [7:0]       lst_add;
   reg              cmp_true;

   wire       busy      = (st_reg != ST_IDLE);
   wire [1:0] iclk      = config_one_reg_reg[`ACS_CONFIG_ONE_REG_ICLK_LSB +: 2];
   wire [1:0] mode      = config_one_reg_reg[`ACS_CONFIG_ONE_REG_MODE_LSB +: 2];
   wire [1:0] divsel    = config_one_reg_reg[`ACS_CONFIG_ONE_REG_DIV_LSB +: 2];
   wire       lsmp      = config_one_reg_reg[`ACS_CONFIG_ONE_REG_LSMP_BIT];
   wire       acken     = config_two_reg_reg[`ACS_CONFIG_TWO_REG_ACKEN_BIT];
   wire       hsc       = config_two_reg_reg[`ACS_CONFIG_TWO_REG_HSC_BIT];
   wire       acfe      = sc2_reg[`ACS_SC2_ACFE_BIT];
   wire       acfgt     = sc2_reg[`ACS_SC2_ACFGT_BIT];
   wire       acren     = sc2_reg[`ACS_SC2_ACREN_BIT];
   wire       cont_en   = sc3_reg[`ACS_SC3_CONT_BIT];
   wire       avg_en    = sc3_reg[`ACS_SC3_AVERAGING_ENABLE_BIT];
   wire [1:0] averaging_count_select      = sc3_reg[`ACS_SC3_AVERAGING_COUNT_SELECT_LSB +: 2];
   wire       async_sel = (iclk == `ACS_ICLK_ASYNC);

   // register write decode
   wire wr_ctl_a = i_wr_en && (i_addr == `ACS_OFS_CTL_A);
   wire wr_ctl_b = i_wr_en && (i_addr == `ACS_OFS_CTL_B);
   wire wr_other = i_wr_en && ((i_addr == `ACS_OFS_CONFIG_ONE_REG) ||
                   (i_addr == `ACS_OFS_CONFIG_TWO_REG) || (i_addr == `ACS_OFS_SC2) ||
                   (i_addr == `ACS_OFS_SC3) || (i_addr == `ACS_OFS_CV1) ||
                   (i_addr == `ACS_OFS_CV2) || (i_addr == `ACS_OFS_RES_A) ||
                   (i_addr == `ACS_OFS_RES_B));
   wire rd_res_a = i_rd_en && (i_addr == `ACS_OFS_RES_A);
   wire rd_res_b = i_rd_en && (i_addr == `ACS_OFS_RES_B);

   // power-mode entries
   wire lp_entry = i_lp_stop && !lpstop_q_reg;
   wire ns_entry = i_normal_stop && !nstop_q_reg && !async_sel &&
                   (iclk != `ACS_ICLK_ALT);
   wire hard_abort = lp_entry;
   wire soft_abort = busy && ((wr_ctl_a && !act_ch_reg) ||
                     (wr_ctl_b && act_ch_reg) ||
                     wr_other || ns_entry);

   // starts: software on primary only, hardware by active select
   wire sw_start = wr_ctl_a && !trg_reg &&
                   (i_wr_data[4:0] != `ACS_CH_OFF);
   wire trig_rise = i_hw_trigger && !trig_q_reg;
   wire hw_start = trg_reg && trig_rise && !busy &&
                   (i_trig_sel_a || i_trig_sel_b);
   wire start_ch = sw_start ? 1'b0 : !i_trig_sel_a;
   wire start = sw_start || hw_start;
   wire async_cold = async_sel && !acken;

   // conversion clock: selected source divided by 1, 2, 4 or 8
   wire async_tick = async_on_reg &&
                     (async_cnt_reg == ASYNC_DIV[7:0] - 8'h01);
   wire src_tick = (iclk == `ACS_ICLK_ASYNC) ? async_tick :
                   (iclk == `ACS_ICLK_ALT)   ? i_alt_clk_tick :
                   (iclk == `ACS_ICLK_BUS2)  ? half_reg : 1'b1;
   wire [2:0] div_mask = (3'h1 << divsel) - 3'h1;
   wire conversion_clock_tick = busy && src_tick &&
                    ((div_reg & div_mask) == div_mask);

   // per-configuration cycle budget
   always @* begin
      case (config_two_reg_reg[`ACS_CONFIG_TWO_REG_LSTS_LSB +: 2])
         2'h0:    lst_add = `ACS_LST_00;
         2'h1:    lst_add = `ACS_LST_01;
         2'h2:    lst_add = `ACS_LST_10;
         default: lst_add = `ACS_LST_11;
      endcase
      if (!lsmp) begin
         lst_add = 8'h00;
      end
   end
   wire [7:0] hsc_add  = hsc ? `ACS_HSC_ADDER : 8'h00;
   wire [7:0] samp_len = `ACS_SAMPLE_BASE + lst_add + hsc_add;
   wire [7:0] base_conversion_time = (mode == `ACS_MODE_8B) ? `ACS_BCT_8B :
                    `ACS_BCT_HI;
   wire [7:0] conv_len = base_conversion_time - `ACS_SAMPLE_BASE;
   wire [7:0] sfc_ck = lsmp ? `ACS_SFC_LONG : `ACS_SFC_SHORT;
   wire [4:0] avg_last = (5'h04 << averaging_count_select) - 5'h01;
   wire more_avg = avg_en && (avg_cnt_reg != avg_last);
   wire more = more_avg || cont_en;

   // result shaping, averaging and compare
   wire [11:0] conv_val = (mode == `ACS_MODE_8B) ? {4'h0, samp_reg[11:4]} :
                          (mode == 2'h2) ? {2'h0, samp_reg[11:2]} :
                          samp_reg;
   wire [16:0] acc_sum = acc_reg + {5'h00, conv_val};
   wire [16:0] avg_shift = acc_sum >> ({1'b0, averaging_count_select} + 3'h2);
   wire [11:0] final_val = avg_en ? avg_shift[11:0] : conv_val;
   always @* begin
      if (!acren) begin
         cmp_true = acfgt ? (final_val >= cv1_reg) : (final_val < cv1_reg);
      end else if (cv1_reg <= cv2_reg) begin
         cmp_true = acfgt ?
            ((final_val >= cv1_reg) && (final_val <= cv2_reg)) :
            ((final_val < cv1_reg) || (final_val > cv2_reg));
      end else begin
         cmp_true = acfgt ?
            ((final_val >= cv1_reg) || (final_val <= cv2_reg)) :
            ((final_val < cv1_reg) && (final_val > cv2_reg));
      end
   end
   wire finish = done_step && !more_avg;
   wire store = finish && (!acfe || cmp_true);

   // sequencing
   always @* begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      done_step = 1'b0;
      if (hard_abort) begin
         st_next = ST_IDLE;
      end else if (start) begin
         if (async_cold) begin
            st_next = ST_WARM;
            cnt_next = STARTUP;
         end else begin
            st_next = ST_FIRST;
            cnt_next = `ACS_SFC_BUS;
         end
      end else if (soft_abort) begin
         st_next = ST_IDLE;
      end else begin
         case (st_reg)
            ST_IDLE: begin
               st_next = ST_IDLE;
            end
            ST_WARM: begin
               cnt_next = cnt_reg - 8'h01;
               if (cnt_reg == 8'h01) begin
                  st_next = ST_FIRST;
                  cnt_next = `ACS_SFC_BUS;
               end
            end
            ST_FIRST: begin
               cnt_next = cnt_reg - 8'h01;
               if (cnt_reg == 8'h01) begin
                  st_next = ST_SFC;
                  cnt_next = sfc_ck;
               end
            end
            ST_SFC: begin
               if (conversion_clock_tick) begin
                  cnt_next = cnt_reg - 8'h01;
                  if (cnt_reg == 8'h01) begin
                     st_next = ST_SAMPLE;
                     cnt_next = samp_len;
                  end
               end
            end
            ST_SAMPLE: begin
               if (conversion_clock_tick) begin
                  cnt_next = cnt_reg - 8'h01;
                  if (cnt_reg == 8'h01) begin
                     st_next = ST_CONV;
                     cnt_next = conv_len;
                  end
               end
            end
            ST_CONV: begin
               if (conversion_clock_tick) begin
                  cnt_next = cnt_reg - 8'h01;
                  if (cnt_reg == 8'h01) begin
                     done_step = 1'b1;
                     st_next = more ? ST_SAMPLE : ST_IDLE;
                     cnt_next = samp_len;
                  end
               end
            end
            default: begin
               st_next = ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         act_ch_reg <= 1'b0;
         avg_cnt_reg <= 5'h00;
         acc_reg <= 17'h00000;
         samp_reg <= 12'h000;
         div_reg <= 3'h0;
         half_reg <= 1'b0;
         busy_reg <= 1'b0;
         sampling_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         busy_reg <= (st_next != ST_IDLE);
         sampling_reg <= (st_next == ST_SAMPLE);
         half_reg <= busy ? !half_reg : 1'b0;
         if (!busy) begin
            div_reg <= 3'h0;
         end else if (src_tick) begin
            div_reg <= div_reg + 3'h1;
         end
         if (st_reg == ST_SAMPLE && conversion_clock_tick && cnt_reg == 8'h01) begin
            samp_reg <= i_analog_in;
         end
         if (start) begin
            act_ch_reg <= start_ch;
            avg_cnt_reg <= 5'h00;
            acc_reg <= 17'h00000;
         end else if (done_step) begin
            if (more_avg) begin
               acc_reg <= acc_sum;
               avg_cnt_reg <= avg_cnt_reg + 5'h01;
            end else begin
               acc_reg <= 17'h00000;
               avg_cnt_reg <= 5'h00;
            end
         end
      end
   end

   // async clock generator: idle unless needed or kept on
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         async_on_reg <= 1'b0;
         async_cnt_reg <= 8'h00;
      end else begin
         async_on_reg <= acken || (async_sel && (st_next != ST_IDLE));
         if (!async_on_reg || async_tick) begin
            async_cnt_reg <= 8'h00;
         end else begin
            async_cnt_reg <= async_cnt_reg + 8'h01;
         end
      end
   end

   // per-channel result, flag and interrupt
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
         wire hit = store && (act_ch_reg == gi);
         wire wr_ctl = (gi == 0) ? wr_ctl_a : wr_ctl_b;
         wire rd_res = (gi == 0) ? rd_res_a : rd_res_b;
         always @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               res_reg[gi] <= {RES_W{1'b0}};
               flag_reg[gi] <= 1'b0;
               irq_pend_reg[gi] <= 1'b0;
            end else begin
               if (hard_abort) begin
                  res_reg[gi] <= {RES_W{1'b0}};
               end else if (hit) begin
                  res_reg[gi] <= final_val[RES_W-1:0];
               end
               if (hit) begin
                  flag_reg[gi] <= 1'b1;
                  irq_pend_reg[gi] <= ien_reg[gi];
               end else if (wr_ctl || rd_res) begin
                  flag_reg[gi] <= 1'b0;
                  irq_pend_reg[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // software registers
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ien_reg <= 2'h0;
         ch_a_reg <= `ACS_CH_OFF;
         ch_b_reg <= `ACS_CH_OFF;
         config_one_reg_reg <= 8'h00;
         config_two_reg_reg <= 4'h0;
         sc2_reg <= 3'h0;
         trg_reg <= 1'b0;
         sc3_reg <= 4'h0;
         cv1_reg <= {RES_W{1'b0}};
         cv2_reg <= {RES_W{1'b0}};
         trig_q_reg <= 1'b0;
         nstop_q_reg <= 1'b0;
         lpstop_q_reg <= 1'b0;
      end else begin
         trig_q_reg <= i_hw_trigger;
         nstop_q_reg <= i_normal_stop;
         lpstop_q_reg <= i_lp_stop;
         if (wr_ctl_a) begin
            ien_reg[0] <= i_wr_data[`ACS_CTL_IEN_BIT];
            ch_a_reg <= i_wr_data[4:0];
         end
         if (wr_ctl_b) begin
            ien_reg[1] <= i_wr_data[`ACS_CTL_IEN_BIT];
            ch_b_reg <= i_wr_data[4:0];
         end
         if (i_wr_en) begin
            case (i_addr)
               `ACS_OFS_CONFIG_ONE_REG: config_one_reg_reg <= i_wr_data[7:0];
               `ACS_OFS_CONFIG_TWO_REG: config_two_reg_reg <= i_wr_data[3:0];
               `ACS_OFS_SC2: begin
                  sc2_reg <= i_wr_data[5:3];
                  trg_reg <= i_wr_data[`ACS_SC2_TRG_BIT];
               end
               `ACS_OFS_SC3: sc3_reg <= i_wr_data[3:0];
               `ACS_OFS_CV1: cv1_reg <= i_wr_data[RES_W-1:0];
               `ACS_OFS_CV2: cv2_reg <= i_wr_data[RES_W-1:0];
               default: begin
               end
            endcase
         end
      end
   end

   // read path
   always @* begin
      rd_mux = 32'h00000000;
      case (i_addr)
         `ACS_OFS_CTL_A: rd_mux = {24'h000000, flag_reg[0], ien_reg[0],
                                   1'b0, ch_a_reg};
         `ACS_OFS_CTL_B: rd_mux = {24'h000000, flag_reg[1], ien_reg[1],
                                   1'b0, ch_b_reg};
         `ACS_OFS_CONFIG_ONE_REG:  rd_mux = {24'h000000, config_one_reg_reg};
         `ACS_OFS_CONFIG_TWO_REG:  rd_mux = {28'h0000000, config_two_reg_reg};
         `ACS_OFS_SC2:   rd_mux = {24'h000000, busy, trg_reg, sc2_reg, 3'h0};
         `ACS_OFS_SC3:   rd_mux = {28'h0000000, sc3_reg};
         `ACS_OFS_RES_A: rd_mux = {{(32-RES_W){1'b0}}, res_reg[0]};
         `ACS_OFS_RES_B: rd_mux = {{(32-RES_W){1'b0}}, res_reg[1]};
         `ACS_OFS_CV1:   rd_mux = {{(32-RES_W){1'b0}}, cv1_reg};
         `ACS_OFS_CV2:   rd_mux = {{(32-RES_W){1'b0}}, cv2_reg};
         default:        rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_data_reg <= 32'h00000000;
         irq_reg <= 1'b0;
      end else begin
         rd_data_reg <= i_rd_en ? rd_mux : 32'h00000000;
         irq_reg <= |irq_pend_reg;
      end
   end

   assign o_rd_data = rd_data_reg;
   assign o_irq = irq_reg;
   assign o_busy = busy_reg;
   assign o_sampling = sampling_reg;
   assign o_async_clk_on = async_on_reg;
endmodule
`default_nettype wire

// >>> verification/acs_sequencer_chk.sv
// assertion checker bound to the conversion sequencer ports
`default_nettype none
`include "acs_regs.vh"
module acs_sequencer_chk (
   input wire logic        i_core_clk,     // core clock
   input wire logic        i_resetn,       // async reset, active low
   input wire logic [7:0]  i_addr,         // register address
   input wire logic [31:0] i_wr_data,      // write data
   input wire logic        i_wr_en,        // write strobe
   input wire logic        i_rd_en,        // read strobe
   input wire logic        i_normal_stop,  // normal stop level
   input wire logic        i_lp_stop,      // low-power stop level
   input wire logic [31:0] o_rd_data,      // read data
   input wire logic        o_irq,          // complete interrupt
   input wire logic        o_busy,         // sequence active
   input wire logic        o_sampling,     // sample phase
   input wire logic        o_async_clk_on  // async generator running
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   logic      trg_reg;
   wire logic acc = i_wr_en | i_rd_en;
   wire logic a_wr = i_wr_en && (i_addr == `ACS_OFS_CTL_A);
   wire logic b_wr = i_wr_en && (i_addr == `ACS_OFS_CTL_B);
   wire logic off = (i_wr_data[4:0] == `ACS_CH_OFF);
   wire logic quiet = !i_lp_stop && !i_normal_stop;
   wire logic other_wr = i_wr_en && (i_addr[1:0] == 2'h0)
      && (i_addr >= `ACS_OFS_CONFIG_ONE_REG) && (i_addr <= `ACS_OFS_CV2);
   // hardware trigger mode as last written to the status register
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn)
         trg_reg <= 1'b0;
      else if (i_wr_en && i_addr == `ACS_OFS_SC2)
         trg_reg <= i_wr_data[`ACS_SC2_TRG_BIT];
   end
   a_rd_data_idle: assert property (!$past(i_rd_en) |-> o_rd_data == 32'h0)
      else $error("read data outside answer cycle");
   a_start_on_write: assert property (
      a_wr && !off && !trg_reg && quiet |-> ##[1:2] o_busy)
      else $error("control write did not start");
   a_off_write_abort: assert property (
      a_wr && off && !trg_reg |-> ##[1:2] !o_busy)
      else $error("off channel write did not abort");
   a_b_write_idle: assert property (b_wr && !o_busy |=> !o_busy [*2])
      else $error("secondary write started a conversion");
   a_mode_write_abort: assert property (other_wr |-> ##[1:2] !o_busy)
      else $error("mode write did not abort");
   a_lp_stop_abort: assert property ($rose(i_lp_stop) |-> ##[1:2] !o_busy)
      else $error("low-power stop did not abort");
   a_sample_in_seq: assert property (
      o_sampling |-> o_busy || $past(o_busy))
      else $error("sampling while idle");
   a_irq_at_done: assert property (
      $rose(o_irq) |-> $past(o_busy) || $past(o_busy, 2))
      else $error("interrupt without completing conversion");
   a_irq_clear_cause: assert property ($fell(o_irq) |->
      $past(acc) || $past(acc, 2) || $past(i_lp_stop) || $past(i_lp_stop, 2))
      else $error("interrupt dropped without access");
   a_async_gated: assert property ($rose(o_async_clk_on) |->
      o_busy || $past(o_busy) || $past(i_wr_en) || $past(i_wr_en, 2))
      else $error("async generator woke while idle");
   c_irq: cover property ($rose(o_irq));
   c_sample_end: cover property ($fell(o_sampling));
   c_lp_abort: cover property ($rose(i_lp_stop) && o_busy);
   c_mode_abort: cover property (other_wr && o_busy);
endmodule
bind acs_sequencer acs_sequencer_chk i_chk (.i_core_clk, .i_resetn, .i_addr,
   .i_wr_data, .i_wr_en, .i_rd_en, .i_normal_stop, .i_lp_stop, .o_rd_data,
   .o_irq, .o_busy, .o_sampling, .o_async_clk_on);
`default_nettype wire

// >>> verification/acs_sequencer_bench.sv
// self-checking testbench of the conversion sequencer
`default_nettype none
`include "acs_regs.vh"
module acs_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_core_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wr_data = 32'h0;
   logic        i_wr_en = 1'b0;
   logic        i_rd_en = 1'b0;
   logic [11:0] i_analog_in = 12'hABC;
   logic        i_alt_clk_tick = 1'b0;
   logic        i_hw_trigger = 1'b0;
   logic        i_trig_sel_a = 1'b0;
   logic        i_trig_sel_b = 1'b0;
   logic        i_normal_stop = 1'b0;
   logic        i_lp_stop = 1'b0;
   wire logic [31:0] o_rd_data;
   wire logic        o_irq, o_busy, o_sampling, o_async_clk_on;
   int          n_fail = 0;
   int          num_checks = 0;
   int          n;
   int          s;
   always #25 i_core_clk = ~i_core_clk;
   acs_sequencer i_dut (.i_core_clk, .i_resetn, .i_addr, .i_wr_data, .i_wr_en,
      .i_rd_en, .i_analog_in, .i_alt_clk_tick, .i_hw_trigger, .i_trig_sel_a,
      .i_trig_sel_b, .i_normal_stop, .i_lp_stop, .o_rd_data, .o_irq, .o_busy,
      .o_sampling, .o_async_clk_on);
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t ns: seen %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wr_data <= v;
      i_wr_en <= 1'b1;
      @(posedge i_core_clk);
      i_wr_en <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_core_clk);
      i_rd_en <= 1'b0;
      @(posedge i_core_clk);
      chk(o_rd_data, exp);
   endtask
   // counts edges until busy is seen low, and sample-phase edges on the way
   task automatic wait_idle;
      s = 0;
      for (n = 1; n < 3000; n++) begin
         @(posedge i_core_clk);
         if (o_sampling === 1'b1) s++;
         if (o_busy === 1'b0 && n > 1) break;
      end
      if (n >= 3000) begin
         n_fail++;
         report_and_stop();
      end
   endtask
   task automatic go(input logic [31:0] ctl, input int t);
      wr(`ACS_OFS_CTL_A, ctl);
      wait_idle();
      @(posedge i_core_clk);
      if (t >= 0) chk(n, t + 1);
      chk(32'(s != 0), 1);
   endtask
   task automatic conv(input logic [31:0] c1, c2, c3, input int t,
                       input logic [31:0] r);
      wr(`ACS_OFS_CONFIG_ONE_REG, c1);
      wr(`ACS_OFS_CONFIG_TWO_REG, c2);
      wr(`ACS_OFS_SC3, c3);
      go(32'h43, t);
      chk(32'(o_irq), 1);
      rdc(`ACS_OFS_CTL_A, 32'hC3);
      rdc(`ACS_OFS_RES_A, r);
      repeat (2) @(posedge i_core_clk);
      chk(32'(o_irq), 0);
   endtask
   task automatic busy_after(input int k, input logic exp);
      repeat (k) @(posedge i_core_clk);
      chk(32'(o_busy), 32'(exp));
   endtask
   initial begin
      repeat (10) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      rdc(`ACS_OFS_CTL_A, 32'h1F);
      rdc(`ACS_OFS_CTL_B, 32'h1F);
      rdc(`ACS_OFS_RES_A, 32'h0);
      rdc(8'h30, 32'h0);
      conv(32'h08, 32'h00, 32'h00, 30, 32'h2AF);
      conv(32'h00, 32'h04, 32'h00, 29, 32'hAB);
      conv(32'h04, 32'h00, 32'h00, 30, 32'hABC);
      conv(32'h14, 32'h00, 32'h00, 48, 32'hABC);
      conv(32'h18, 32'h01, 32'h00, 40, 32'h2AF);
      conv(32'h18, 32'h02, 32'h00, 34, 32'h2AF);
      conv(32'h10, 32'h07, 32'h00, 29, 32'hAB);
      conv(32'h08, 32'h00, 32'h04, 90, 32'h2AF);
      conv(32'h08, 32'h00, 32'h05, 170, 32'h2AF);
      conv(32'h08, 32'h00, 32'h06, 330, 32'h2AF);
      conv(32'h08, 32'h00, 32'h07, 650, 32'h2AF);
      i_analog_in <= 12'h400;
      wr(`ACS_OFS_SC3, 32'h0);
      wr(`ACS_OFS_CV1, 32'h0);
      wr(`ACS_OFS_SC2, 32'h20);
      go(32'h43, 30);
      chk(32'(o_irq), 0);
      rdc(`ACS_OFS_CTL_A, 32'h43);
      rdc(`ACS_OFS_RES_A, 32'h2AF);
      wr(`ACS_OFS_CV1, 32'h200);
      conv(32'h08, 32'h00, 32'h04, 90, 32'h100);
      wr(`ACS_OFS_SC2, 32'h0);
      wr(`ACS_OFS_SC3, 32'h0);
      wr(`ACS_OFS_CTL_A, 32'h43);
      repeat (10) @(posedge i_core_clk);
      wr(`ACS_OFS_CTL_A, 32'h5F);
      busy_after(3, 1'b0);
      rdc(`ACS_OFS_CTL_A, 32'h5F);
      rdc(`ACS_OFS_RES_A, 32'h100);
      wr(`ACS_OFS_CTL_A, 32'h03);
      repeat (10) @(posedge i_core_clk);
      go(32'h03, 30);
      wr(`ACS_OFS_CTL_A, 32'h03);
      repeat (10) @(posedge i_core_clk);
      wr(`ACS_OFS_CV2, 32'h0);
      busy_after(3, 1'b0);
      rdc(`ACS_OFS_RES_A, 32'h100);
      wr(`ACS_OFS_CTL_A, 32'h03);
      repeat (10) @(posedge i_core_clk);
      i_lp_stop <= 1'b1;
      busy_after(3, 1'b0);
      i_lp_stop <= 1'b0;
      rdc(`ACS_OFS_RES_A, 32'h0);
      wr(`ACS_OFS_CTL_A, 32'h03);
      repeat (10) @(posedge i_core_clk);
      i_normal_stop <= 1'b1;
      busy_after(3, 1'b0);
      i_normal_stop <= 1'b0;
      wr(`ACS_OFS_CONFIG_ONE_REG, 32'h0A);
      i_alt_clk_tick <= 1'b1;
      fork
         go(32'h03, 30);
         begin
            repeat (12) @(posedge i_core_clk);
            i_normal_stop <= 1'b1;
         end
      join
      i_normal_stop <= 1'b0;
      rdc(`ACS_OFS_RES_A, 32'h100);
      wr(`ACS_OFS_CONFIG_ONE_REG, 32'h08);
      wr(`ACS_OFS_SC2, 32'h40);
      wr(`ACS_OFS_CTL_B, 32'h43);
      busy_after(2, 1'b0);
      i_trig_sel_b <= 1'b1;
      @(posedge i_core_clk);
      i_hw_trigger <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      wait_idle();
      i_hw_trigger <= 1'b0;
      rdc(`ACS_OFS_CTL_B, 32'hC3);
      rdc(`ACS_OFS_CTL_A, 32'h03);
      rdc(`ACS_OFS_RES_B, 32'h100);
      i_hw_trigger <= 1'b1;
      repeat (10) @(posedge i_core_clk);
      wr(`ACS_OFS_CTL_B, 32'h43);
      busy_after(3, 1'b0);
      i_hw_trigger <= 1'b0;
      i_trig_sel_b <= 1'b0;
      wr(`ACS_OFS_SC2, 32'h0);
      wr(`ACS_OFS_SC3, 32'h08);
      wr(`ACS_OFS_CTL_A, 32'h03);
      busy_after(80, 1'b1);
      rdc(`ACS_OFS_CTL_A, 32'h83);
      wr(`ACS_OFS_SC3, 32'h0);
      busy_after(3, 1'b0);
      wr(`ACS_OFS_CONFIG_ONE_REG, 32'h0B);
      wr(`ACS_OFS_CONFIG_TWO_REG, 32'h0);
      repeat (3) @(posedge i_core_clk);
      chk(32'(o_async_clk_on), 0);
      go(32'h03, -1);
      chk(32'(n >= 200), 1);
      repeat (3) @(posedge i_core_clk);
      chk(32'(o_async_clk_on), 0);
      wr(`ACS_OFS_CONFIG_TWO_REG, 32'h08);
      repeat (3) @(posedge i_core_clk);
      chk(32'(o_async_clk_on), 1);
      repeat (`ACS_STARTUP_CYC) @(posedge i_core_clk);
      go(32'h03, -1);
      chk(32'(n < 130), 1);
      report_and_stop();
   end
endmodule
`default_nettype wire
